// ===== design/mac_frame_ctrl_backoff.sv
// Control settings, receive filtering and transmit backoff of the MAC.
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
// Overview of operation
// - With broadcast_block set every received broadcast word is dropped.
// - With retry disabled a collision abandons the frame with a retry error.
// - With retry enabled a frame gets 16 attempts before a retry error.
// - With pad stripping on, frames with length below 46 lose pad and FCS.
// - With pad stripping on, frames with length 46 or more pass whole.
// - With pad stripping off, every frame not dropped by broadcast_block passes unchanged.
// - After a collision the MAC waits r slot times, r below 2 to the K.
// - The wait value is the low K bits of a 20-bit LFSR.
// - The wait counts down once per slot time before the next attempt.
// - With wake-up enabled a broadcast wake-up frame raises wake-up.
// - The backoff_limit code caps the bits used at 10, 8, 4 or 1.
module mac_frame_ctrl_backoff (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] rx_in_data,
  input wire logic rx_in_valid,
  input wire logic rx_in_last,
  input wire logic rx_in_broadcast,
  input wire logic rx_in_wakeup,
  input wire logic [15:0] rx_in_len_field,
  output logic rx_in_ready,
  output logic [31:0] rx_out_data,
  output logic rx_out_valid,
  output logic rx_out_last,
  input wire logic rx_out_ready,
  output logic wakeup,
  input wire logic tx_start,
  input wire logic tx_collision,
  input wire logic tx_end,
  output logic tx_attempt,
  output logic tx_retry_error,
  output logic tx_frame_done
);
  import mac_ctrl_pkg::*;
  default clocking main_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Number of LFSR bits used: min(attempts, 10, cap of backoff_limit).
  function automatic logic [4:0] wait_bits(input logic [4:0] n,
                                           input logic [1:0] lim);
    logic [4:0] k;
    logic [4:0] cap;
    k = (n < k_cap) ? n : k_cap;
    case (lim)
      2'h0: cap = 5'h0A;
      2'h1: cap = 5'h08;
      2'h2: cap = 5'h04;
      default: cap = 5'h01;
    endcase
    wait_bits = (k < cap) ? k : cap;
  endfunction

  logic [31:0] ctrl_q;
  logic aw_got_q, w_got_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic broadcast_block, retry_disable, pad_strip_enable, wake_en;
  logic [1:0] backoff_limit;
  logic [15:0] retry_err_count_q;
  logic [15:0] dropped_count_q;

  assign broadcast_block = ctrl_q[broadcast_block_bit];
  assign retry_disable = ctrl_q[retry_disable_bit];
  assign pad_strip_enable = ctrl_q[pad_strip_enable_bit];
  assign backoff_limit = ctrl_q[backoff_limit_lsb +: 2];
  assign wake_en = ctrl_q[wakeup_frame_enable_bit];

  // Write channel: address and data are taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= axi_okay;
      ctrl_q <= ctrl_reset;
    end else begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q[7:2] == ctrl_offset[7:2]) begin
          for (int i = 0; i < 4; i++) begin
            if (wstrb_q[i]) begin
              ctrl_q[i*8 +: 8] <= wdata_q[i*8 +: 8];
            end
          end
          s_axi_bresp <= axi_okay;
        end else if (awaddr_q[7:2] == status_offset[7:2] ||
                     awaddr_q[7:2] == counters_offset[7:2]) begin
          s_axi_bresp <= axi_okay;
        end else begin
          s_axi_bresp <= axi_slverr;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  tx_state_type state_q;
  logic [4:0] attempts_q;
  logic [9:0] backoff_q;
  logic [11:0] slot_q;
  logic [19:0] lfsr_q;

  // Read channel: one cycle from address taken to data valid.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= axi_okay;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= axi_okay;
        if (s_axi_araddr[7:2] == ctrl_offset[7:2]) begin
          s_axi_rdata <= ctrl_q;
        end else if (s_axi_araddr[7:2] == status_offset[7:2]) begin
          s_axi_rdata <= {12'h000, backoff_q, 1'b0, attempts_q, state_q};
        end else if (s_axi_araddr[7:2] == counters_offset[7:2]) begin
          s_axi_rdata <= {dropped_count_q, retry_err_count_q};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= axi_slverr;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Receive path: words are kept, dropped or trimmed before the buffer.
  logic [31:0] buf_data_q [2];
  logic [1:0] buf_last_q;
  logic buf_wr_q, buf_rd_q;
  logic [1:0] buf_cnt_q;
  logic in_frame_q, drop_q, strip_q;
  logic [15:0] kept_bytes_q;
  logic first_word, frame_drop, frame_strip, keep_word, push, pop;
  logic [15:0] payload_bytes;

  assign first_word = !in_frame_q;
  assign frame_drop = first_word ? (broadcast_block && rx_in_broadcast)
                                 : drop_q;
  assign frame_strip = first_word ? (pad_strip_enable &&
                                     rx_in_len_field < min_len_field)
                                  : strip_q;
  // Header (14 bytes) plus length-field payload are the bytes kept.
  assign payload_bytes = first_word ? rx_in_len_field + 16'h000E
                                    : kept_bytes_q;
  // pad and FCS words past the payload are discarded.
  assign keep_word = !frame_drop &&
                     (!frame_strip || payload_bytes != 16'h0000);
  assign pop = rx_out_valid && rx_out_ready;
  assign push = rx_in_valid && rx_in_ready && keep_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_frame_q <= 1'b0;
      drop_q <= 1'b0;
      strip_q <= 1'b0;
      kept_bytes_q <= 16'h0000;
      dropped_count_q <= 16'h0000;
      wakeup <= 1'b0;
    end else begin
      wakeup <= 1'b0;
      if (rx_in_valid && rx_in_ready) begin
        in_frame_q <= !rx_in_last;
        drop_q <= frame_drop;
        strip_q <= frame_strip;
        kept_bytes_q <= (payload_bytes > 16'h0004) ?
                        payload_bytes - 16'h0004 : 16'h0000;
        if (first_word && frame_drop) begin
          dropped_count_q <= dropped_count_q + 16'h0001;
        end
        if (first_word && wake_en && rx_in_broadcast && rx_in_wakeup) begin
          wakeup <= 1'b1;
        end
      end
    end
  end

  // Two-entry buffer; a trimmed frame ends on its last kept word.
  logic push_last;
  assign push_last = rx_in_last ||
                     (frame_strip && payload_bytes <= 16'h0004);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_wr_q <= 1'b0;
      buf_rd_q <= 1'b0;
      buf_cnt_q <= 2'h0;
      buf_last_q <= 2'h0;
      buf_data_q[0] <= 32'h0000_0000;
      buf_data_q[1] <= 32'h0000_0000;
      rx_out_valid <= 1'b0;
      rx_out_data <= 32'h0000_0000;
      rx_out_last <= 1'b0;
      rx_in_ready <= 1'b0;
    end else begin
      // Ready is registered, so it looks ahead at the count after this edge.
      rx_in_ready <= (buf_cnt_q + 2'(push) - 2'(pop)) != 2'h2;
      if (push) begin
        buf_data_q[buf_wr_q] <= rx_in_data;
        buf_last_q[buf_wr_q] <= push_last;
        buf_wr_q <= !buf_wr_q;
      end
      if (pop) begin
        buf_rd_q <= !buf_rd_q;
      end
      buf_cnt_q <= buf_cnt_q + 2'(push) - 2'(pop);
      if (!rx_out_valid || pop) begin
        if (buf_cnt_q - 2'(pop) != 2'h0) begin
          rx_out_valid <= 1'b1;
          rx_out_data <= buf_data_q[buf_rd_q ^ pop];
          rx_out_last <= buf_last_q[buf_rd_q ^ pop];
        end else if (push) begin
          rx_out_valid <= 1'b1;
          rx_out_data <= rx_in_data;
          rx_out_last <= push_last;
        end else begin
          rx_out_valid <= 1'b0;
        end
      end
    end
  end

  // free-running 20-bit LFSR, taps 20 and 17.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= lfsr_seed;
    end else begin
      lfsr_q <= {lfsr_q[18:0], lfsr_q[19] ^ lfsr_q[16]};
    end
  end

  // Transmit attempt control with truncated exponential backoff.
  logic [4:0] nbits;
  logic [9:0] mask;
  assign nbits = wait_bits(attempts_q, backoff_limit);
  assign mask = 10'((20'h00001 << nbits) - 20'h00001);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= tx_idle;
      attempts_q <= 5'h00;
      backoff_q <= 10'h000;
      slot_q <= 12'h000;
      tx_attempt <= 1'b0;
      tx_retry_error <= 1'b0;
      tx_frame_done <= 1'b0;
      retry_err_count_q <= 16'h0000;
    end else begin
      tx_attempt <= 1'b0;
      tx_retry_error <= 1'b0;
      tx_frame_done <= 1'b0;
      case (state_q)
        tx_idle: begin
          if (tx_start) begin
            attempts_q <= 5'h01;
            tx_attempt <= 1'b1;
            state_q <= tx_send;
          end
        end
        tx_send: begin
          if (tx_collision) begin
            // give up after one or sixteen attempts.
            if (retry_disable || attempts_q == max_attempts) begin
              tx_retry_error <= 1'b1;
              retry_err_count_q <= retry_err_count_q + 16'h0001;
              state_q <= tx_done;
            end else begin
              // wait drawn from the low bits.
              backoff_q <= lfsr_q[9:0] & mask;
              slot_q <= slot_cycles - 12'h001;
              state_q <= tx_wait;
            end
          end else if (tx_end) begin
            state_q <= tx_done;
          end
        end
        tx_wait: begin
          // count down one per slot time.
          if (backoff_q == 10'h000) begin
            attempts_q <= attempts_q + 5'h01;
            tx_attempt <= 1'b1;
            state_q <= tx_send;
          end else if (slot_q == 12'h000) begin
            slot_q <= slot_cycles - 12'h001;
            backoff_q <= backoff_q - 10'h001;
          end else begin
            slot_q <= slot_q - 12'h001;
          end
        end
        default: begin
          tx_frame_done <= 1'b1;
          state_q <= tx_idle;
        end
      endcase
    end
  end

  // Retry disabled means the very first collision ends the frame.
  single_try_a: assert property (
    state_q == tx_send && tx_collision && retry_disable |=> tx_retry_error)
    else $error("collision with retry off gave no retry error");
  sixteen_tries_a: assert property (
    tx_retry_error && !retry_disable |-> attempts_q == max_attempts)
    else $error("retry error before sixteen attempts");
  backoff_range_a: assert property (
    state_q == tx_wait |-> (backoff_q & ~mask) == 10'h000)
    else $error("backoff wider than allowed bits");
  limit_one_a: assert property (
    state_q == tx_wait && backoff_limit == 2'h3 |-> backoff_q <= 10'h001)
    else $error("limit code 3 allowed more than one bit");
  first_retry_a: assert property (
    state_q == tx_wait && attempts_q == 5'h01 |-> backoff_q <= 10'h001)
    else $error("first backoff exceeds one slot");
  zero_wait_a: assert property (
    state_q == tx_wait && backoff_q == 10'h000 |=> tx_attempt)
    else $error("no attempt after backoff expired");
  slot_step_a: assert property (
    state_q == tx_wait && $past(state_q) == tx_wait &&
    backoff_q != $past(backoff_q) |-> $past(slot_q) == 12'h000)
    else $error("backoff stepped before a slot ended");
  broadcast_block_drop_a: assert property (
    rx_in_valid && first_word && broadcast_block && rx_in_broadcast
    |-> !push)
    else $error("blocked broadcast word reached the buffer");
  pass_whole_a: assert property (
    rx_in_valid && rx_in_ready && !pad_strip_enable && !broadcast_block
    |-> push)
    else $error("word lost with stripping off");
  wake_pulse_a: assert property (
    rx_in_valid && rx_in_ready && first_word && wake_en &&
    rx_in_broadcast && rx_in_wakeup |=> wakeup)
    else $error("broadcast wake-up frame gave no wake-up");
  backoff_seen_c: cover property (@(posedge aclk) state_q == tx_wait);
  retry_error_c: cover property (@(posedge aclk) tx_retry_error);
  stall_full_c: cover property (@(posedge aclk) buf_cnt_q == 2'h2);
  strip_c: cover property (@(posedge aclk) push && frame_strip && push_last);
endmodule

// ===== design/mac_ctrl_pkg.sv
// Package with register map, field positions and timing counts of the block.
package mac_ctrl_pkg;
  localparam logic [7:0] ctrl_offset = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] counters_offset = 8'h08;
  localparam int broadcast_block_bit = 11;
  localparam int retry_disable_bit = 10;
  localparam int pad_strip_enable_bit = 8;
  localparam int backoff_limit_lsb = 6;
  localparam int wakeup_frame_enable_bit = 0;
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [4:0] max_attempts = 5'h10;
  localparam logic [4:0] k_cap = 5'h0A;
  localparam logic [19:0] lfsr_seed = 20'h00001;
  localparam logic [15:0] min_len_field = 16'h002E;
  localparam int slot_bits = 512;
  localparam int bit_time_ns = 100;
  localparam int clk_period_ns = 40;
  localparam int slot_time_ns = slot_bits * bit_time_ns;
  localparam logic [11:0] slot_cycles = 12'(slot_time_ns / clk_period_ns);
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;
  typedef enum logic [3:0] {
    tx_idle = 4'h1,
    tx_send = 4'h2,
    tx_wait = 4'h4,
    tx_done = 4'h8
  } tx_state_type;
endpackage

// ===== bench/phy_model.sv
// Far-side model of the half-duplex medium answering each transmit attempt.
`timescale 1ns/100ps
module phy_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic tx_attempt,
  input wire logic collide,
  input wire logic [3:0] delay,
  output logic tx_collision,
  output logic tx_end
);
  logic [3:0] busy_q;
  // The outcome comes a set time into the attempt, so a slow medium is
  // modelled by a larger delay.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 4'h0;
      tx_collision <= 1'b0;
      tx_end <= 1'b0;
    end else begin
      tx_collision <= 1'b0;
      tx_end <= 1'b0;
      if (tx_attempt) begin
        busy_q <= delay;
      end else if (busy_q != 4'h0) begin
        busy_q <= busy_q - 4'h1;
        if (busy_q == 4'h1) begin
          tx_collision <= collide;
          tx_end <= !collide;
        end
      end
    end
  end
endmodule

// ===== bench/tb_mac_frame_ctrl_backoff.sv
// Self-checking testbench of the MAC control and backoff block.
`timescale 1ns/100ps
module tb_mac_frame_ctrl_backoff;
  import mac_ctrl_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, d, rx_in_data;
  logic rx_in_valid, rx_in_last, rx_in_bc, rx_in_wake, rx_out_ready;
  logic [15:0] rx_in_len;
  logic tx_start, collide, tx_col, tx_end;
  logic [3:0] delay, sink_q;
  logic [1:0] r;
  wire logic awready, wready, bvalid, arready, rvalid, rx_in_ready;
  wire logic rx_out_valid, rx_out_last, wakeup, tx_att, tx_err, tx_done;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, rx_out_data;
  int failures = 0, total_checks = 0, out_cnt, last_cnt, wake_cnt;
  int att_cnt, err_cnt, done_cnt, gap, max_gap;

  mac_frame_ctrl_backoff u_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_in_data(rx_in_data),
    .rx_in_valid(rx_in_valid), .rx_in_last(rx_in_last),
    .rx_in_broadcast(rx_in_bc), .rx_in_wakeup(rx_in_wake),
    .rx_in_len_field(rx_in_len), .rx_in_ready(rx_in_ready),
    .rx_out_data(rx_out_data), .rx_out_valid(rx_out_valid),
    .rx_out_last(rx_out_last), .rx_out_ready(rx_out_ready),
    .wakeup(wakeup), .tx_start(tx_start), .tx_collision(tx_col),
    .tx_end(tx_end), .tx_attempt(tx_att), .tx_retry_error(tx_err),
    .tx_frame_done(tx_done));
  phy_model u_phy (.aclk(aclk), .aresetn(aresetn), .tx_attempt(tx_att),
    .collide(collide), .delay(delay), .tx_collision(tx_col),
    .tx_end(tx_end));

  always #20 aclk = ~aclk;
  // The sink takes one word in four, so the buffer fills and refuses.
  always @(posedge aclk) begin
    if (rx_out_valid && rx_out_ready) begin
      chk(rx_out_data, 32'(out_cnt)); // words in order
      out_cnt++;
      if (rx_out_last) last_cnt++;
    end
    if (wakeup) wake_cnt++;
    if (tx_att) begin
      att_cnt++;
      if (gap > max_gap) max_gap = gap;
    end
    if (tx_err) err_cnt++;
    if (tx_done) done_cnt++;
    gap = tx_col ? 0 : gap + 1;
    sink_q <= sink_q + 4'h1;
    rx_out_ready <= (sink_q[1:0] == 2'h0);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Only the watchdog ends a wait for a bus answer.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic frame(input int nw, input logic bc, input logic [15:0] len);
    int i;
    i = 0;
    out_cnt = 0;
    last_cnt = 0;
    wake_cnt = 0;
    @(posedge aclk);
    rx_in_valid <= 1'b1;
    rx_in_bc <= bc;
    rx_in_wake <= bc;
    rx_in_len <= len;
    rx_in_data <= 32'h0;
    rx_in_last <= (nw == 1);
    while (i < nw) begin
      @(posedge aclk);
      if (rx_in_ready) begin
        i++;
        rx_in_data <= 32'(i);
        rx_in_last <= (i == nw - 1);
        if (i == nw) rx_in_valid <= 1'b0;
      end
    end
    repeat (80) @(posedge aclk);
  endtask

  task automatic tx_frame(input logic col, input logic [3:0] dly);
    att_cnt = 0;
    err_cnt = 0;
    done_cnt = 0;
    max_gap = 0;
    gap = 0;
    collide <= col;
    delay <= dly;
    tx_start <= 1'b1;
    @(posedge aclk);
    tx_start <= 1'b0;
    while (done_cnt == 0) begin
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask

  task automatic test_regs();
    axi_rd(ctrl_offset); // read after reset
    chk(d, ctrl_reset); // control reset value
    axi_wr(ctrl_offset, 32'h0000_0DC1); // set every field
    chk({30'h0, r}, {30'h0, axi_okay}); // write accepted
    axi_rd(ctrl_offset); // read back
    chk(d, 32'h0000_0DC1); // field stored
    axi_rd(8'h0C); // unmapped read
    chk({30'h0, r}, {30'h0, axi_slverr}); // read refused
    chk(d, 32'h0); // refused read data
    axi_wr(8'h0C, 32'h1); // unmapped write
    chk({30'h0, r}, {30'h0, axi_slverr}); // write refused
  endtask

  task automatic test_broadcast_block();
    axi_wr(ctrl_offset, 32'h0000_0801); // block broadcast
    frame(4, 1'b1, 16'h0040); // blocked frame
    chk(32'(out_cnt), 32'h0); // dropped
    axi_wr(ctrl_offset, 32'h0000_0001); // allow broadcast
    frame(4, 1'b1, 16'h0040); // allowed frame
    chk(32'(out_cnt), 32'h4); // passed
    chk(32'(wake_cnt), 32'h1); // wake-up pulse
    axi_rd(counters_offset); // read counters
    chk(d, 32'h0001_0000); // drop count
  endtask

  task automatic test_pad();
    axi_wr(ctrl_offset, 32'h0000_0100); // stripping on
    frame(16, 1'b0, 16'h0004); // short frame
    chk(32'(out_cnt), 32'h5); // stripped
    chk(32'(last_cnt), 32'h1); // last on final kept word
    frame(16, 1'b0, 16'h002D); // one below the bound
    chk(32'(out_cnt), 32'hF); // boundary
    frame(16, 1'b0, min_len_field); // at the bound
    chk(32'(out_cnt), 32'h10); // kept
    chk(32'(last_cnt), 32'h1); // last on final word
    axi_wr(ctrl_offset, 32'h0); // stripping off
    frame(16, 1'b0, 16'h0004); // short frame
    chk(32'(out_cnt), 32'h10); // unchanged
    chk(32'(last_cnt), 32'h1); // last on final word
  endtask

  task automatic test_tx();
    axi_wr(ctrl_offset, 32'h0000_0400); // retry off
    tx_frame(1'b1, 4'h2); // colliding frame
    chk(32'(att_cnt), 32'h1); // one attempt
    chk(32'(err_cnt), 32'h1); // retry error
    chk(32'(done_cnt), 32'h1); // moves on
    axi_wr(ctrl_offset, 32'h0000_00C0); // retry on, one-bit limit
    tx_frame(1'b1, 4'hC); // colliding frame
    chk(32'(att_cnt), 32'(max_attempts)); // count
    chk(32'(err_cnt), 32'h1); // error after last attempt
    chk(32'(max_gap <= slot_cycles + 32), 32'h1); // one bit wait
    chk(32'(max_gap >= slot_cycles), 32'h1); // whole slot counted
    tx_frame(1'b0, 4'h2); // clean frame
    chk(32'(err_cnt), 32'h0); // no error
    chk(32'(att_cnt), 32'h1); // no wait without collision
    axi_rd(counters_offset); // read counters
    chk(d, 32'h0001_0002); // error count
  endtask

  // The limit is several times the longest expected run, so only a hang
  // reaches it.
  initial begin
    #3000000;
    failures++;
    print_verdict();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    rx_in_data = 32'h0;
    rx_in_valid = 1'b0;
    rx_in_last = 1'b0;
    rx_in_bc = 1'b0;
    rx_in_wake = 1'b0;
    rx_in_len = 16'h0;
    rx_out_ready = 1'b0;
    sink_q = 4'h0;
    tx_start = 1'b0;
    collide = 1'b0;
    delay = 4'h2;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    test_regs();
    test_broadcast_block();
    test_pad();
    test_tx();
    print_verdict();
  end
endmodule
